/* src/tcs_timer2.v */
// Purpose: timer clock select, prescaler, and timer 2 auto-reload timer
// Assumes: one 20 MHz clock; external clock sampled as a plain input no faster than clk/2
// Notes: every divided clock is a one-cycle count enable in the clk domain
`timescale 1ns/1ps
`include "tcs_regs.vh"

// Function
// - Timer 3 high select counts only in split
// - Timer 3 low select: system or alternate
// - Timer 1 select ignored in counter mode
// - Timer 0 select ignored in counter mode
// - Prescale code picks /12 /4 /48 ext/8
// - External clock synchronised before any use
// - Timer 2 sixteen bit or split eight
// - Sixteen-bit wrap reloads and sets high flag
// - High flag requests interrupt when enabled
// - Low wrap requests with low enable too
// - Split bytes reload from own reload byte
// - Run gates all, or high only split
// - Alternate clock is /12 or ext/8
// - Low select: system or alternate clock
// - High select used only in split
// - Low and high wraps set their flags
// - Split: high overflow, or low overflow with low enable, requests interrupt
// - Flags cleared only by software zero write
// - Control bits 4 and 1 read zero
// - Counter bytes readable and writable
module tcs_timer2 #(
	parameter DIV_W = 6
)(
	input wire clk,
	input wire rst,
	input wire ce,
	input wire ext_clk,
	input wire cpu_timer_irq_enable,
	input wire tim0_counter_mode,
	input wire tim1_counter_mode,
	input wire tim3_split_mode,
	input wire tim3_alt_clock_sel,
	input wire [7:0] sfr_addr,
	input wire [7:0] sfr_wdata,
	input wire sfr_wr,
	input wire sfr_rd,
	output reg [7:0] sfr_rdata,
	output reg timer2_irq,
	output reg tim0_tick,
	output reg tim1_tick,
	output reg tim3_low_tick,
	output reg tim3_high_tick
);

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	reg [7:0] timer_clock_select;
	reg [7:0] timer2_control;
	reg [7:0] reload_low;
	reg [7:0] reload_high;
	reg [7:0] count_low;
	reg [7:0] count_high;
	reg ext_s1;
	reg ext_s2;
	reg ext_s3;
	reg [2:0] ext_div;
	reg [DIV_W-1:0] div12_cnt;
	reg [DIV_W-1:0] div4_cnt;
	reg [DIV_W-1:0] div48_cnt;

	wire [1:0] prescale_code = timer_clock_select[1:0];
	wire tim3_high_clk_sel = timer_clock_select[`TCS_CS_T3H];
	wire tim3_low_clk_sel = timer_clock_select[`TCS_CS_T3L];
	wire tim_b_high_clk_sel = timer_clock_select[`TCS_CS_T2H];
	wire tim_b_low_clk_sel = timer_clock_select[`TCS_CS_T2L];
	wire tim1_clk_sel = timer_clock_select[`TCS_CS_T1];
	wire tim0_clk_sel = timer_clock_select[`TCS_CS_T0];
	wire high_overflow_flag = timer2_control[`TCS_T2_HFLAG];
	wire low_overflow_flag = timer2_control[`TCS_T2_LFLAG];
	wire low_overflow_irq_en = timer2_control[`TCS_T2_LIRQEN];
	wire split_mode = timer2_control[`TCS_T2_SPLIT];
	wire run_control = timer2_control[`TCS_T2_RUN];
	wire alt_clock_sel = timer2_control[`TCS_T2_ALTCLK];

	// Shared decode for the register selects
	function hit;
		input [7:0] a;
		input [7:0] target;
		begin
			hit = (a == target);
		end
	endfunction

	// ------------------------------------------------------------
	// External clock synchroniser and divide-by-8
	// ------------------------------------------------------------
	// Edge detect reads stages two and three only, never the first flop
	wire ext_rise = ext_s2 & ~ext_s3;
	wire ext8_tick = ext_rise && (ext_div == `TCS_EXT8_LAST);
	always @(posedge clk)
	begin
		if (rst)
		begin
			ext_s1 <= 1'b0;
			ext_s2 <= 1'b0;
			ext_s3 <= 1'b0;
			ext_div <= 3'h0;
		end
		else if (ce)
		begin
			ext_s1 <= ext_clk;
			ext_s2 <= ext_s1;
			ext_s3 <= ext_s2;
			if (ext_rise)
				ext_div <= ext_div + 3'h1;
		end
	end

	// ------------------------------------------------------------
	// System clock dividers as count enables
	// ------------------------------------------------------------
	// Free-running so a mode switch never waits on a stale count
	wire div12_tick = (div12_cnt == `TCS_DIV12_LAST);
	wire div4_tick = (div4_cnt == `TCS_DIV4_LAST);
	wire div48_tick = (div48_cnt == `TCS_DIV48_LAST);
	always @(posedge clk)
	begin
		if (rst)
		begin
			div12_cnt <= {DIV_W{1'b0}};
			div4_cnt <= {DIV_W{1'b0}};
			div48_cnt <= {DIV_W{1'b0}};
		end
		else if (ce)
		begin
			div12_cnt <= div12_tick ? {DIV_W{1'b0}} : div12_cnt + 1'b1;
			div4_cnt <= div4_tick ? {DIV_W{1'b0}} : div4_cnt + 1'b1;
			div48_cnt <= div48_tick ? {DIV_W{1'b0}} : div48_cnt + 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Clock selection
	// ------------------------------------------------------------
	reg prescale_tick;
	always @*
	begin
		case (prescale_code)
			`TCS_PS_DIV12: prescale_tick = div12_tick;
			`TCS_PS_DIV4: prescale_tick = div4_tick;
			`TCS_PS_DIV48: prescale_tick = div48_tick;
			`TCS_PS_EXT8: prescale_tick = ext8_tick;
			default: prescale_tick = 1'b0;
		endcase
	end

	wire alt_tick = alt_clock_sel ? ext8_tick : div12_tick;
	wire t3_alt_tick = tim3_alt_clock_sel ? ext8_tick : div12_tick;
	wire low_en = tim_b_low_clk_sel ? 1'b1 : alt_tick;
	// High select only matters split; 16-bit carries from the low byte
	wire high_clk_en = tim_b_high_clk_sel ? 1'b1 : alt_tick;
	wire t3_low_en = tim3_low_clk_sel ? 1'b1 : t3_alt_tick;
	wire t3_high_en = (tim3_split_mode && tim3_high_clk_sel) ? 1'b1 : t3_alt_tick;

	// Counter mode takes its own pin edges, so the timer 0 and 1 ticks go quiet
	always @(posedge clk)
	begin
		if (rst)
		begin
			tim0_tick <= 1'b0;
			tim1_tick <= 1'b0;
			tim3_low_tick <= 1'b0;
			tim3_high_tick <= 1'b0;
		end
		else if (ce)
		begin
			tim0_tick <= ~tim0_counter_mode & (tim0_clk_sel | prescale_tick);
			tim1_tick <= ~tim1_counter_mode & (tim1_clk_sel | prescale_tick);
			tim3_low_tick <= t3_low_en;
			tim3_high_tick <= tim3_split_mode ? t3_high_en : t3_low_en;
		end
	end

	// ------------------------------------------------------------
	// Timer 2 counting
	// ------------------------------------------------------------
	// Split: low always runs, high gated by run; 16-bit: run gates both
	wire low_step = low_en && (split_mode || run_control);
	wire low_wrap = low_step && (count_low == 8'hFF);
	wire high_step = split_mode ? (run_control && high_clk_en) : low_wrap;
	wire high_wrap = high_step && (count_high == 8'hFF);
	reg [7:0] next_count_low;
	reg [7:0] next_count_high;
	always @*
	begin
		next_count_low = count_low;
		next_count_high = count_high;
		if (split_mode)
		begin
			if (low_step)
				next_count_low = low_wrap ? reload_low : count_low + 8'h01;
			if (high_step)
				next_count_high = high_wrap ? reload_high : count_high + 8'h01;
		end
		else if (low_step)
		begin
			if (high_wrap)
			begin
				next_count_low = reload_low;
				next_count_high = reload_high;
			end
			else
			begin
				next_count_low = count_low + 8'h01;
				if (low_wrap)
					next_count_high = count_high + 8'h01;
			end
		end
	end

	// ------------------------------------------------------------
	// Register writes, counter update and flags
	// ------------------------------------------------------------
	// Software writes win over counting for the bytes; flag sets win over clears
	wire [7:0] ctrl_wr_val = sfr_wdata & `TCS_T2_WMASK;
	wire ctrl_wr = sfr_wr && hit(sfr_addr, `TCS_ADDR_T2_CTRL);
	always @(posedge clk)
	begin
		if (rst)
		begin
			timer_clock_select <= `TCS_CLK_SEL_RESET;
			timer2_control <= `TCS_T2_CTRL_RESET;
			reload_low <= 8'h00;
			reload_high <= 8'h00;
			count_low <= 8'h00;
			count_high <= 8'h00;
		end
		else if (ce)
		begin
			if (sfr_wr && hit(sfr_addr, `TCS_ADDR_CLK_SEL))
				timer_clock_select <= sfr_wdata;
			if (ctrl_wr)
				timer2_control <= ctrl_wr_val;
			if (sfr_wr && hit(sfr_addr, `TCS_ADDR_RELOAD_LOW))
				reload_low <= sfr_wdata;
			if (sfr_wr && hit(sfr_addr, `TCS_ADDR_RELOAD_HIGH))
				reload_high <= sfr_wdata;
			count_low <= (sfr_wr && hit(sfr_addr, `TCS_ADDR_COUNT_LOW)) ?
				sfr_wdata : next_count_low;
			count_high <= (sfr_wr && hit(sfr_addr, `TCS_ADDR_COUNT_HIGH)) ?
				sfr_wdata : next_count_high;
			// Wraps set flags here; the write path above can also clear or set them
			if (high_wrap)
				timer2_control[`TCS_T2_HFLAG] <= 1'b1;
			if (low_wrap)
				timer2_control[`TCS_T2_LFLAG] <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Interrupt request and read data
	// ------------------------------------------------------------
	// Level request; holds while an enabled flag stays set and the CPU enable is high
	always @(posedge clk)
	begin
		if (rst)
		begin
			timer2_irq <= 1'b0;
			sfr_rdata <= 8'h00;
		end
		else if (ce)
		begin
			timer2_irq <= cpu_timer_irq_enable & (high_overflow_flag |
				(low_overflow_flag & low_overflow_irq_en));
			if (sfr_rd)
			begin
				if (hit(sfr_addr, `TCS_ADDR_CLK_SEL))
					sfr_rdata <= timer_clock_select;
				else if (hit(sfr_addr, `TCS_ADDR_T2_CTRL))
					sfr_rdata <= timer2_control & `TCS_T2_WMASK;
				else if (hit(sfr_addr, `TCS_ADDR_RELOAD_LOW))
					sfr_rdata <= reload_low;
				else if (hit(sfr_addr, `TCS_ADDR_RELOAD_HIGH))
					sfr_rdata <= reload_high;
				else if (hit(sfr_addr, `TCS_ADDR_COUNT_LOW))
					sfr_rdata <= count_low;
				else if (hit(sfr_addr, `TCS_ADDR_COUNT_HIGH))
					sfr_rdata <= count_high;
				else
					sfr_rdata <= 8'h00;
			end
		end
	end

endmodule

/* src/tcs_regs.vh */
// Purpose: register offsets, field positions and reset values for the timer clock block
// Assumes: 8-bit special-function register port, byte addresses as printed
// Notes: definitions only
`ifndef TCS_REGS_VH
`define TCS_REGS_VH

`define TCS_ADDR_CLK_SEL 8'h8E
`define TCS_ADDR_T2_CTRL 8'hC8
`define TCS_ADDR_RELOAD_LOW 8'hCA
`define TCS_ADDR_RELOAD_HIGH 8'hCB
`define TCS_ADDR_COUNT_LOW 8'hCC
`define TCS_ADDR_COUNT_HIGH 8'hCD

`define TCS_CLK_SEL_RESET 8'h00
`define TCS_T2_CTRL_RESET 8'h00

// Clock-select register fields
`define TCS_CS_T3H 7
`define TCS_CS_T3L 6
`define TCS_CS_T2H 5
`define TCS_CS_T2L 4
`define TCS_CS_T1 3
`define TCS_CS_T0 2

// Timer 2 control fields
`define TCS_T2_HFLAG 7
`define TCS_T2_LFLAG 6
`define TCS_T2_LIRQEN 5
`define TCS_T2_SPLIT 3
`define TCS_T2_RUN 2
`define TCS_T2_ALTCLK 0
`define TCS_T2_WMASK 8'hED

// Prescale codes and divide ratios
`define TCS_PS_DIV12 2'h0
`define TCS_PS_DIV4 2'h1
`define TCS_PS_DIV48 2'h2
`define TCS_PS_EXT8 2'h3
`define TCS_DIV12_LAST 6'h0B
`define TCS_DIV4_LAST 6'h03
`define TCS_DIV48_LAST 6'h2F
`define TCS_EXT8_LAST 3'h7

`endif

/* bench/tcs_timer2_props.sv */
// Purpose: port-level assertions for the timer clock block
// Assumes: sees only the top ports; clock select shadowed from writes
// Notes: period checks wait for settled modes
`timescale 1ns/1ps
module tcs_timer2_props (
	input wire clk,
	input wire rst,
	input wire ce,
	input wire ext_clk,
	input wire cpu_timer_irq_enable,
	input wire tim0_counter_mode,
	input wire tim1_counter_mode,
	input wire tim3_split_mode,
	input wire tim3_alt_clock_sel,
	input wire [7:0] sfr_addr,
	input wire [7:0] sfr_wdata,
	input wire sfr_wr,
	input wire sfr_rd,
	input wire [7:0] sfr_rdata,
	input wire timer2_irq,
	input wire tim0_tick,
	input wire tim1_tick,
	input wire tim3_low_tick,
	input wire tim3_high_tick
);
reg [7:0] cs;
reg [5:0] gap;
reg [6:0] age;
default clocking @(posedge clk); endclocking
default disable iff (rst);
// Shadow select, cycles since a tick, age of the timer 0 setup
always @(posedge clk)
begin
	if (rst || (sfr_wr && sfr_addr == 8'h8E) || tim0_counter_mode || !ce)
		age <= 7'h00;
	else if (age != 7'h7F)
		age <= age + 7'h01;
	if (rst || tim0_tick)
		gap <= 6'h00;
	else if (gap != 6'h3F)
		gap <= gap + 6'h01;
	if (rst)
		cs <= 8'h00;
	else if (ce && sfr_wr && sfr_addr == 8'h8E)
		cs <= sfr_wdata;
end
// ----------------------------------------
// Assertions
// ----------------------------------------
t0_cmode_a: assert property ((tim0_counter_mode && ce) [*2] |-> !tim0_tick)
	else $error("timer 0 tick in counter mode");
t1_cmode_a: assert property ((tim1_counter_mode && ce) [*2] |-> !tim1_tick)
	else $error("timer 1 tick in counter mode");
t0_sys_a: assert property ((cs[2] && ce && !tim0_counter_mode) [*3] |-> tim0_tick)
	else $error("timer 0 missing system tick");
t1_sys_a: assert property ((cs[3] && ce && !tim1_counter_mode) [*3] |-> tim1_tick)
	else $error("timer 1 missing system tick");
t3l_sys_a: assert property ((cs[6] && ce) [*3] |-> tim3_low_tick)
	else $error("timer 3 low missing system tick");
t3h_sys_a: assert property ((cs[7] && tim3_split_mode && ce) [*3] |-> tim3_high_tick)
	else $error("timer 3 high missing system tick");
ps_period_a: assert property (tim0_tick && age > 7'h70 && !cs[2] && cs[1:0] != 2'h3 |->
	gap == (cs[1:0] == 2'h0 ? 6'h0B : cs[1:0] == 2'h1 ? 6'h03 : 6'h2F))
	else $error("prescaled tick period wrong");
irq_gate_a: assert property ((!cpu_timer_irq_enable && ce) [*2] |-> !timer2_irq)
	else $error("interrupt while disabled");
irq_hold_a: assert property (timer2_irq && cpu_timer_irq_enable && !sfr_wr
	&& !$past(sfr_wr) |=> timer2_irq)
	else $error("interrupt dropped without write");
unused_rd_a: assert property (ce && sfr_rd && sfr_addr == 8'hC8 |=>
	sfr_rdata[4] == 1'b0 && sfr_rdata[1] == 1'b0)
	else $error("unused control bits read one");
rdata_hold_a: assert property (!(ce && sfr_rd) |=> $stable(sfr_rdata))
	else $error("read data moved without read");
endmodule
bind tcs_timer2 tcs_timer2_props u_props (.clk(clk), .rst(rst), .ce(ce), .ext_clk(ext_clk),
	.cpu_timer_irq_enable(cpu_timer_irq_enable), .tim0_counter_mode(tim0_counter_mode),
	.tim1_counter_mode(tim1_counter_mode), .tim3_split_mode(tim3_split_mode),
	.tim3_alt_clock_sel(tim3_alt_clock_sel), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
	.sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .timer2_irq(timer2_irq),
	.tim0_tick(tim0_tick), .tim1_tick(tim1_tick), .tim3_low_tick(tim3_low_tick),
	.tim3_high_tick(tim3_high_tick));

/* bench/tcs_timer2_test.sv */
// Purpose: register-level tests of the timer clock block
// Assumes: inputs change on the falling edge
// Notes: one idle cycle between accesses keeps strobes single-assigned
`timescale 1ns/1ps
`define CHK(n, e, s) begin num_checks = num_checks + 1; if ((s) !== (e)) begin \
	fail_count = fail_count + 1; $display("[FAIL] %s exp %h got %h", n, e, s); end end
module tcs_timer2_test;
reg clk = 1'b0;
reg rst = 1'b1;
reg ce = 1'b1;
reg ext_clk = 1'b0;
reg irq_en = 1'b0;
reg cm0 = 1'b0;
reg cm1 = 1'b0;
reg split3 = 1'b0;
reg alt3 = 1'b0;
reg [7:0] addr = 8'h00;
reg [7:0] wdata = 8'h00;
reg wr = 1'b0;
reg rd = 1'b0;
wire [7:0] rdata;
wire irq, t0, t1, t3l, t3h;
integer fail_count = 0;
integer num_checks = 0;
integer cyc = 0;
integer i, n, m, h;
tcs_timer2 uut (.clk(clk), .rst(rst), .ce(ce), .ext_clk(ext_clk),
	.cpu_timer_irq_enable(irq_en), .tim0_counter_mode(cm0), .tim1_counter_mode(cm1),
	.tim3_split_mode(split3), .tim3_alt_clock_sel(alt3), .sfr_addr(addr),
	.sfr_wdata(wdata), .sfr_wr(wr), .sfr_rd(rd), .sfr_rdata(rdata), .timer2_irq(irq),
	.tim0_tick(t0), .tim1_tick(t1), .tim3_low_tick(t3l), .tim3_high_tick(t3h));
// Clocks; external clock offset so its edges never meet clk edges
initial forever #25 clk = ~clk;
initial begin #10; forever #75 ext_clk = ~ext_clk; end
// Hang guard, far above the expected run
always @(posedge clk)
begin
	cyc = cyc + 1;
	if (cyc == 10000)
	begin
		fail_count = fail_count + 1;
		summarize;
	end
end
// ----------------------------------------
// Access tasks
// ----------------------------------------
task acc(input w, input [7:0] a, input [7:0] d);
begin
	@(negedge clk);
	wr = w;
	rd = !w;
	addr = a;
	wdata = d;
	@(negedge clk);
	wr = 1'b0;
	rd = 1'b0;
end
endtask
task rdc(input [7:0] a, input [7:0] e);
begin
	acc(1'b0, a, 8'h00);
	`CHK("rdata", e, rdata)
end
endtask
task summarize;
begin
	$display("checks %0d fails %0d", num_checks, fail_count);
	if (fail_count == 0 && num_checks > 0)
		$display("verification passed");
	else
		$display("verification failed");
	$finish;
end
endtask
initial
begin
	repeat (20) @(negedge clk);
	rst = 1'b0;
	rdc(8'h8E, 8'h00);
	for (i = 0; i < 6; i = i + 1)
		rdc(8'hC8 + i[7:0], 8'h00);
	rdc(8'h90, 8'h00);
	acc(1'b1, 8'hC8, 8'hFF);
	rdc(8'hC8, 8'hED);
	`CHK("irq", 1'b0, irq)
	irq_en = 1'b1;
	repeat (2) @(negedge clk);
	`CHK("irq", 1'b1, irq)
	acc(1'b1, 8'hC8, 8'h00);
	@(negedge clk);
	`CHK("irq", 1'b0, irq)
	acc(1'b1, 8'hCC, 8'h12);
	acc(1'b1, 8'hCD, 8'h34);
	rdc(8'hCC, 8'h12);
	rdc(8'hCD, 8'h34);
	// Sixteen-bit wrap from 0xFFFE in exactly two steps
	acc(1'b1, 8'h8E, 8'h10);
	acc(1'b1, 8'hCA, 8'h56);
	acc(1'b1, 8'hCB, 8'h78);
	acc(1'b1, 8'hCD, 8'hFF);
	acc(1'b1, 8'hCC, 8'hFE);
	acc(1'b1, 8'hC8, 8'h04);
	// Stop lands on the wrap edge: the hardware set must beat the zero write
	acc(1'b1, 8'hC8, 8'h00);
	rdc(8'hCC, 8'h56);
	rdc(8'hCD, 8'h78);
	rdc(8'hC8, 8'hC0);
	`CHK("irq", 1'b1, irq)
	acc(1'b1, 8'hC8, 8'h40);
	@(negedge clk);
	`CHK("irq", 1'b0, irq)
	acc(1'b1, 8'hC8, 8'h60);
	@(negedge clk);
	`CHK("irq", 1'b1, irq)
	// Split: low runs alone, high runs two steps under run control
	acc(1'b1, 8'h8E, 8'h30);
	acc(1'b1, 8'hCA, 8'hFE);
	acc(1'b1, 8'hCB, 8'hF0);
	acc(1'b1, 8'hCC, 8'hFE);
	acc(1'b1, 8'hCD, 8'hFE);
	acc(1'b1, 8'hC8, 8'h08);
	acc(1'b1, 8'hC8, 8'h0C);
	acc(1'b1, 8'hC8, 8'h08);
	rdc(8'hCD, 8'hF0);
	rdc(8'hC8, 8'hC8);
	acc(1'b1, 8'hC8, 8'h00);
	// Split low byte on the alternate clock: 120 clock cycles on /12, then 120 on ext/8
	acc(1'b1, 8'h8E, 8'h00);
	acc(1'b1, 8'hCC, 8'h00);
	acc(1'b1, 8'hC8, 8'h08);
	repeat (118) @(negedge clk);
	acc(1'b1, 8'hC8, 8'h09);
	repeat (118) @(negedge clk);
	acc(1'b1, 8'hC8, 8'h00);
	rdc(8'hCC, 8'h0F);
	split3 = 1'b1;
	acc(1'b1, 8'h8E, 8'hCC);
	repeat (5) @(negedge clk);
	cm0 = 1'b1;
	cm1 = 1'b1;
	repeat (4) @(negedge clk);
	`CHK("tick0", 1'b0, t0)
	`CHK("tick1", 1'b0, t1)
	cm0 = 1'b0;
	cm1 = 1'b0;
	alt3 = 1'b1;
	// Each prescale code counted over a window of whole periods
	for (i = 0; i < 4; i = i + 1)
	begin
		acc(1'b1, 8'h8E, i[7:0]);
		repeat (60) @(negedge clk);
		n = 0;
		m = 0;
		h = 0;
		repeat (480)
		begin
			@(negedge clk);
			n = n + t1;
			m = m + t3l;
			h = h + t3h;
		end
		`CHK("ticks", i == 0 ? 40 : i == 1 ? 120 : 10 + 10 * (i - 2), n)
		`CHK("tick3", 20, m)
		`CHK("tick3h", 20, h)
	end
	summarize;
end
endmodule
